// [virtual_partition_map_regs.sv]
// mapping registers 4 and 5: access decode, storage and translation lookup
// Functional notes
// - decode register 4 from op0 3, op1 4, CRn 10, CRm 6, op2 4
// - any access from exception level 0 is undefined
// - at EL1 with EL2 on and both nested bits set, redirect to 0x960, or 0x968 for register 5
// - EL1 nested-only access traps class 0x18, to EL3 or EL2
// - at EL2, trap to EL3 if present and trap-lower set, else access
// - at EL3 always access a present register directly
// - register 5 holds virtual partitions 20 to 23
// - entry n+3 in bits 63:48 down to entry n in bits 15:0
// - id field gives highest map index, at most 7
// - kernel and user identifiers translate only under their own enable
// - an entry is used only while its valid bit is set
// - register 5 exists only with hyp control and index above 4
// - mapping is ignored while EL2 is not enabled
// - entries hold no reset value; software writes them first
// - each map register is one 64-bit word of four entries
// - register 4 holds virtual partitions 16 to 19
// ****************************************
// usage notes
// ****************************************
// one access is taken on each rising edge that sees acc_valid high
// with an encoding that selects register 4 or register 5
// any other encoding is simply ignored and gives no response pulse
// the answer stands for exactly one cycle, one edge after the request
// a direct write is visible to a read issued on the very next edge
// redirected and trapped writes leave the stored words untouched,
// because the real store for a redirect lives in memory, not here
// the presence test comes first, so an absent register is always
// undefined whatever the exception level of the request
// the trap routing only names a target level; taking the exception
// and building the full syndrome is left to the core around us
// lookups cover virtual partitions 16 to 23 only; callers must route
// lower and higher identifiers to the blocks that own those words
// a lookup also needs its register to be implemented, so the index
// field must reach the register number of the requested entry
// a miss returns an all-zero entry so that a stray value from an
// unloaded word never leaks out while the hit flag is low
// storage has no reset on purpose: it saves area, and the mapping
// is meaningless until software has loaded and enabled it anyway
// hazard: enabling translation before writing the words returns
// unknown physical identifiers, which simulation shows as x
// the response outputs do reset, so a checker never sees x pulses
// every output is a flip-flop, trading one cycle of latency for
// clean timing into the core's exception and memory paths
`include "vpart_map_params.svh"
module virtual_partition_map_regs
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic [1:0]  acc_op0,
    input  wire logic [2:0]  acc_op1,
    input  wire logic [3:0]  acc_crn,
    input  wire logic [3:0]  acc_crm,
    input  wire logic [2:0]  acc_op2,
    input  wire logic [63:0] acc_wdata,
    input  wire logic [1:0]  cur_el,
    input  wire logic        el2_enabled,
    input  wire logic        el3_present,
    input  wire logic        nested_virt_enable,
    input  wire logic        nested_virt_redirect,
    input  wire logic        trap_lower_levels,
    input  wire logic        hyp_control_present,
    input  wire logic [2:0]  highest_map_register_index,
    input  wire logic        kernel_map_enable,
    input  wire logic        user_map_enable,
    input  wire logic [31:0] entry_valid_bits,
    input  wire logic        lookup_valid,
    input  wire logic        lookup_kernel,
    input  wire logic [4:0]  lookup_vpart,
    output logic             resp_valid,
    output vpart_map_pkg::result_t resp_result,
    output logic [63:0]      resp_rdata,
    output logic [11:0]      redirect_offset,
    output logic [5:0]       trap_class,
    output logic             map_hit,
    output logic [15:0]      physical_partition_entry
);
    // ****************************************
    // access decode and routing
    // ****************************************
    logic                   sel4;
    logic                   sel5;
    logic                   present;
    vpart_map_pkg::result_t res;
    logic [11:0]            ofs;
    logic [63:0]            map4_q;
    logic [63:0]            map4_d;
    logic [63:0]            map5_q;
    logic [63:0]            map5_d;
    logic                   resp_valid_d;
    logic [63:0]            rdata_d;
    logic                   hit_d;
    logic [15:0]            entry_d;
    logic [63:0]            word;
    logic                   in_range;

    // both registers share all fields except op2
    always_comb
    begin
        sel4 = acc_op0 == `SYS_OP0 && acc_op1 == `SYS_OP1
            && acc_crn == `SYS_CRN && acc_crm == `SYS_CRM
            && acc_op2 == `MAP4_OP2;
        sel5 = acc_op0 == `SYS_OP0 && acc_op1 == `SYS_OP1
            && acc_crn == `SYS_CRN && acc_crm == `SYS_CRM
            && acc_op2 == `MAP5_OP2;
        present = hyp_control_present && (sel4 ?
            highest_map_register_index > `MAP4_MIN_INDEX :
            highest_map_register_index > `MAP5_MIN_INDEX);
        ofs = sel5 ? `MAP5_REDIR_OFS : `MAP4_REDIR_OFS;
        res = vpart_map_pkg::RES_NONE;
        if (acc_valid && (sel4 || sel5))
        begin
            if (!present)
                res = vpart_map_pkg::RES_UNDEF;
            else
            begin
                case (cur_el)
                    2'h0: res = vpart_map_pkg::RES_UNDEF;
                    2'h1:
                    begin
                        if (el2_enabled && nested_virt_enable
                            && nested_virt_redirect)
                            res = vpart_map_pkg::RES_REDIR;
                        else if (el2_enabled && nested_virt_enable)
                            res = (el3_present && trap_lower_levels) ?
                                vpart_map_pkg::RES_TRAP3 :
                                vpart_map_pkg::RES_TRAP2;
                        else
                            res = vpart_map_pkg::RES_UNDEF;
                    end
                    2'h2: res = (el3_present && trap_lower_levels) ?
                        vpart_map_pkg::RES_TRAP3 :
                        vpart_map_pkg::RES_DONE;
                    2'h3: res = vpart_map_pkg::RES_DONE;
                    default: res = vpart_map_pkg::RES_UNDEF;
                endcase
            end
        end
    end

    // ****************************************
    // storage
    // ****************************************
    // writes land only on a direct access; redirected writes go to memory
    always_comb
    begin
        map4_d = map4_q;
        map5_d = map5_q;
        if (res == vpart_map_pkg::RES_DONE && acc_write)
        begin
            if (sel4)
                map4_d = acc_wdata;
            else
                map5_d = acc_wdata;
        end
        resp_valid_d = res != vpart_map_pkg::RES_NONE;
        rdata_d = 64'h0;
        if (res == vpart_map_pkg::RES_DONE && !acc_write)
            rdata_d = sel4 ? map4_q : map5_q;
    end

    // entries carry no reset: software must load them before enabling
    always_ff @(posedge clk)
    begin
        map4_q <= map4_d;
        map5_q <= map5_d;
    end

    // ****************************************
    // translation lookup
    // ****************************************
    // only virtual partitions 16 to 23 live here; others report a miss
    always_comb
    begin
        word = lookup_vpart[2] ? map5_q : map4_q;
        entry_d = word[lookup_vpart[1:0]*`ENTRY_W +: `ENTRY_W];
        in_range = lookup_vpart[4:3] == 2'h2;
        hit_d = lookup_valid && in_range && el2_enabled
            && hyp_control_present
            && highest_map_register_index >= lookup_vpart[4:2]
            && (lookup_kernel ? kernel_map_enable
                              : user_map_enable)
            && entry_valid_bits[lookup_vpart];
        if (!hit_d)
            entry_d = 16'h0;
    end

    // all outputs registered, one cycle after the request
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            resp_valid               <= 1'b0;
            resp_result              <= vpart_map_pkg::RES_NONE;
            resp_rdata               <= 64'h0;
            redirect_offset          <= 12'h0;
            trap_class               <= 6'h0;
            map_hit                  <= 1'b0;
            physical_partition_entry <= 16'h0;
        end
        else
        begin
            resp_valid      <= resp_valid_d;
            resp_result     <= res;
            resp_rdata      <= rdata_d;
            redirect_offset <= (res == vpart_map_pkg::RES_REDIR) ?
                ofs : 12'h0;
            trap_class      <= (res == vpart_map_pkg::RES_TRAP2
                || res == vpart_map_pkg::RES_TRAP3) ?
                `TRAP_CLASS : 6'h0;
            map_hit                  <= hit_d;
            physical_partition_entry <= entry_d;
        end
    end
endmodule

// [vpart_map_params.svh]
// constants for the virtual partition map register block
`ifndef VPART_MAP_PARAMS_SVH
`define VPART_MAP_PARAMS_SVH
`define SYS_OP0            2'h3
`define SYS_OP1            3'h4
`define SYS_CRN            4'ha
`define SYS_CRM            4'h6
`define MAP4_OP2           3'h4
`define MAP5_OP2           3'h5
`define MAP4_REDIR_OFS     12'h960
`define MAP5_REDIR_OFS     12'h968
`define TRAP_CLASS         6'h18
`define MAP4_MIN_INDEX     3'h3
`define MAP5_MIN_INDEX     3'h4
`define MAP4_FIRST_VPART   5'h10
`define MAP5_FIRST_VPART   5'h14
`define ENTRY_W            16
`endif

// [vpart_map_pkg.sv]
// types for the virtual partition map register block
package vpart_map_pkg;
    typedef enum logic [2:0]
    {
        RES_NONE   = 3'b000,
        RES_DONE   = 3'b001,
        RES_UNDEF  = 3'b010,
        RES_TRAP2  = 3'b011,
        RES_TRAP3  = 3'b100,
        RES_REDIR  = 3'b101
    } result_t;
endpackage

// [vpart_map_chk_sva.sv]
// assertion checker on the virtual partition map register ports
module vpart_map_chk
(
    input wire logic clk, rst_b, acc_valid, el2_enabled, el3_present,
    input wire logic trap_lower_levels, hyp_control_present, lookup_valid,
    input wire logic resp_valid, map_hit,
    input wire logic [1:0] cur_el,
    input wire logic [2:0] acc_op2, highest_map_register_index,
    input wire logic [5:0] trap_class,
    input wire logic [11:0] redirect_offset,
    input wire vpart_map_pkg::result_t resp_result
);
    // both registers present; index above four covers register 4 too
    wire pres = hyp_control_present && highest_map_register_index > 3'h4;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // answers land one cycle after the access or lookup that caused them
    AST_RESP_CAUSE: assert property (!acc_valid |=> !resp_valid)
        else $error("response without access");
    AST_EL0_UNDEF: assert property (acc_valid && cur_el == 2'h0
        |=> !resp_valid || resp_result == vpart_map_pkg::RES_UNDEF)
        else $error("el0 access not undefined");
    AST_REDIR_OFS: assert property (resp_valid &&
        resp_result == vpart_map_pkg::RES_REDIR |-> redirect_offset ==
        ($past(acc_op2) == 3'h4 ? 12'h960 : 12'h968))
        else $error("wrong redirect offset");
    AST_TRAP_CLASS: assert property (resp_valid && resp_result
        inside {vpart_map_pkg::RES_TRAP2, vpart_map_pkg::RES_TRAP3}
        |-> trap_class == 6'h18) else $error("wrong trap class");
    AST_EL2_TRAP: assert property (acc_valid && cur_el == 2'h2 && pres
        && el3_present && trap_lower_levels
        |=> !resp_valid || resp_result == vpart_map_pkg::RES_TRAP3)
        else $error("el2 access not trapped");
    AST_EL3_DONE: assert property (acc_valid && cur_el == 2'h3 && pres
        |=> !resp_valid || resp_result == vpart_map_pkg::RES_DONE)
        else $error("el3 access not performed");
    AST_ABSENT: assert property (acc_valid && !hyp_control_present
        |=> !resp_valid || resp_result == vpart_map_pkg::RES_UNDEF)
        else $error("absent register not undefined");
    AST_EL2_OFF: assert property (lookup_valid && !el2_enabled
        |=> !map_hit) else $error("lookup hit with el2 off");
endmodule
bind virtual_partition_map_regs vpart_map_chk vpart_map_chk_i (.*);

// [testbench.sv]
// self-checking bench for the virtual partition map register block
`include "vpart_map_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0, rst_b = 1'h0, acc_valid = 1'h0, acc_write = 1'h0;
    logic el2_enabled = 1'h1, el3_present = 1'h0, trap_lower_levels = 1'h0;
    logic nested_virt_enable = 1'h0, nested_virt_redirect = 1'h0;
    logic hyp_control_present = 1'h1, kernel_map_enable = 1'h1;
    logic user_map_enable = 1'h0, lookup_valid = 1'h0, lookup_kernel = 1'h0;
    logic resp_valid, map_hit;
    logic [1:0] cur_el = 2'h0;
    logic [2:0] acc_op2 = 3'h0, highest_map_register_index = 3'h7;
    logic [4:0] lookup_vpart = 5'h0;
    logic [5:0] trap_class;
    logic [11:0] redirect_offset;
    logic [15:0] physical_partition_entry;
    logic [31:0] entry_valid_bits = 32'hffffffff;
    logic [63:0] acc_wdata = 64'h0, resp_rdata;
    vpart_map_pkg::result_t resp_result;
    int err_total = 0, num_checks = 0, cycles = 0;
    // arbitrary physical values, distinct per entry to catch lane swaps
    localparam logic [63:0] va = 64'h4a19_4a18_4a17_4a16;
    localparam logic [63:0] vb = 64'h5b23_5b22_5b21_5b20;
    virtual_partition_map_regs virtual_partition_map_regs_i (.*,
        .acc_op0(`SYS_OP0), .acc_op1(`SYS_OP1), .acc_crn(`SYS_CRN),
        .acc_crm(`SYS_CRM));
    initial forever #2.5 clk = ~clk;
    // the tests need about 54 cycles; a hang is cut well after that
    always @(posedge clk)
        if (++cycles == 2000)
        begin
            err_total++;
            end_of_test;
        end
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [85:0] got, input logic [85:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // codes: 0 none, 1 done, 2 undefined, 3 trap el2, 4 trap el3, 5 redirect
    task acc(input logic w, input logic [2:0] o2, input logic [1:0] el,
             input logic [2:0] r, input logic [63:0] d);
        logic [63:0] e;
        logic [11:0] f;
        logic [5:0]  t;
        e = (!w && r == 3'h1) ? d : 64'h0;
        f = (r != 3'h5) ? 12'h0 :
            (o2 == `MAP4_OP2) ? `MAP4_REDIR_OFS : `MAP5_REDIR_OFS;
        t = (r == 3'h3 || r == 3'h4) ? `TRAP_CLASS : 6'h0;
        @(posedge clk);
        acc_valid <= 1'h1;
        acc_write <= w;
        acc_op2 <= o2;
        cur_el <= el;
        acc_wdata <= d;
        @(posedge clk);
        acc_valid <= 1'h0;
        #1 chk({redirect_offset, trap_class, resp_valid, resp_result,
                resp_rdata}, {f, t, r != 3'h0, r, e});
    endtask
    task look(input logic k, input logic [4:0] v, input logic [15:0] e);
        @(posedge clk);
        lookup_valid <= 1'h1;
        lookup_kernel <= k;
        lookup_vpart <= v;
        @(posedge clk);
        lookup_valid <= 1'h0;
        #1 chk({map_hit, physical_partition_entry}, {e != 16'h0, e});
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        acc(1'h1, 3'h4, 2'h2, 3'h1, va);
        {el3_present, trap_lower_levels} <= 2'h3;
        acc(1'h1, 3'h5, 2'h3, 3'h1, vb);
        acc(1'h0, 3'h5, 2'h3, 3'h1, vb);
        acc(1'h0, 3'h4, 2'h2, 3'h4, va);
        acc(1'h0, 3'h4, 2'h0, 3'h2, va);
        acc(1'h0, 3'h3, 2'h3, 3'h0, va);
        {nested_virt_enable, nested_virt_redirect} <= 2'h3;
        acc(1'h1, 3'h4, 2'h1, 3'h5, vb);
        acc(1'h0, 3'h5, 2'h1, 3'h5, vb);
        nested_virt_redirect <= 1'h0;
        acc(1'h0, 3'h4, 2'h1, 3'h4, va);
        el3_present <= 1'h0;
        acc(1'h1, 3'h4, 2'h1, 3'h3, vb);
        acc(1'h0, 3'h4, 2'h3, 3'h1, va);
        nested_virt_enable <= 1'h0;
        acc(1'h0, 3'h4, 2'h1, 3'h2, va);
        highest_map_register_index <= 3'h4;
        acc(1'h0, 3'h5, 2'h3, 3'h2, vb);
        acc(1'h0, 3'h4, 2'h3, 3'h1, va);
        hyp_control_present <= 1'h0;
        acc(1'h0, 3'h4, 2'h3, 3'h2, va);
        {hyp_control_present, highest_map_register_index} <= 4'hf;
        look(1'h1, 5'h11, va[31:16]);
        look(1'h1, 5'h17, vb[63:48]);
        look(1'h0, 5'h14, 16'h0);
        user_map_enable <= 1'h1;
        look(1'h0, 5'h14, vb[15:0]);
        highest_map_register_index <= 3'h4;
        look(1'h1, 5'h16, 16'h0);
        look(1'h1, 5'h12, va[47:32]);
        highest_map_register_index <= 3'h7;
        entry_valid_bits[21] <= 1'h0;
        look(1'h1, 5'h15, 16'h0);
        el2_enabled <= 1'h0;
        look(1'h1, 5'h16, 16'h0);
        end_of_test;
    end
endmodule
